// file: spm_top.v
`timescale 1ns/1ps
`default_nettype none
`include "spm_consts.vh"

// What this block does
// - Frame length code 00 is 8 bits, 01 is 16, 11 is 24, 10 also runs as 24.
// - Cycle-complete flag sets whenever a serial transaction finishes.
// - Writing 0 clears the flag; starting a new transaction also clears it.
// - Idle bit and phase bit together choose clock idle level and active edge.
// - Unused bits 14, 11 and 8 of second control register read as 1.
// - The 24-bit word is three read/write byte registers, low to high.
// - A write to the top data byte while no frame runs starts a transaction with current settings.
// - Routing field steers the interrupt to none, IRQ3, IRQ4, IRQ5 or IRQ10.
// - Bits 7 to 4 of the routing register are unused and read as 1.
// - Peripherals may raise the shared interrupt only while enable bit 15 is set.
// - Clock rate field: 00 gives 1 MHz, 10 gives 2 MHz, 11 gives 8 MHz.
module spm_top (
  input wire CLOCK,
  input wire NRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire MISO,
  input wire PERIPH_IRQ_N,
  output wire SCLK,
  output wire MOSI,
  output reg [2:0] CHIP_SEL,
  output wire XFER_ACTIVE,
  output reg IRQ,
  output reg [3:0] IRQ_LINES
);
  reg [7:0] con1_reg;
  reg [7:0] con1_next;
  reg [7:0] con2_reg;
  reg [7:0] con2_next;
  reg [7:0] dat1_reg;
  reg [7:0] dat1_next;
  reg [7:0] dat2_reg;
  reg [7:0] dat2_next;
  reg [7:0] dat3_reg;
  reg [7:0] dat3_next;
  reg [3:0] route_reg;
  reg [3:0] route_next;
  reg [1:0] stat_reg;
  reg [1:0] stat_next;
  reg [1:0] mask_reg;
  reg [1:0] mask_next;
  reg start_reg;
  reg start_next;
  reg [7:0] half_cnt;
  reg [7:0] rd_byte;
  reg mapped;
  reg [3:0] lines_next;

  wire [9:0] idx;
  wire setup;
  wire access;
  wire wr_en;
  wire rd_en;
  wire [1:0] miso_irq_sync;
  wire peri_req;
  wire shf_busy;
  wire shf_done;
  wire [23:0] shf_rx;
  wire [7:0] wbyte;

  assign idx = PADDR[11:2];
  assign wbyte = PWDATA[7:0];
  // The request is only acted upon in the access cycle that completes it.
  assign setup = PSEL && !PENABLE && !PREADY;
  assign access = PSEL && PENABLE && PREADY;
  assign wr_en = access && PWRITE && !PSLVERR;
  assign rd_en = access && !PWRITE && !PSLVERR;

  spm_sync #(
    .W(2)
  ) u_sync (
    .clk(CLOCK),
    .rst_n(NRST),
    .async_in({PERIPH_IRQ_N, MISO}),
    .sync_out(miso_irq_sync)
  );

  // Request is low-active on the pin and only counts while enabled.
  assign peri_req = !miso_irq_sync[1] && con2_reg[`SPM_CON2_IEN];

  // Half periods are small, so only their low byte reaches the divider.
  localparam [31:0] half_1m = `SPM_HALF_1M;
  localparam [31:0] half_2m = `SPM_HALF_2M;
  localparam [31:0] half_8m = `SPM_HALF_8M;

  // Clock rate from the first control register; the unlisted code runs at 1 MHz.
  always @* begin
    case (con1_reg[`SPM_CON1_RATE_HI:`SPM_CON1_RATE_LO])
      2'h2: half_cnt = half_2m[7:0];
      2'h3: half_cnt = half_8m[7:0];
      default: half_cnt = half_1m[7:0];
    endcase
  end

  spm_shifter u_shifter (
    .clk(CLOCK),
    .rst_n(NRST),
    .start(start_reg),
    .word({dat3_reg, dat2_reg, dat1_reg}),
    .len_code(con2_reg[`SPM_CON2_LEN_HI:`SPM_CON2_LEN_LO]),
    .cpol(~con2_reg[`SPM_CON2_CI]),
    .cpha(con1_reg[`SPM_CON1_CP]),
    .half_cnt(half_cnt),
    .miso(miso_irq_sync[0]),
    .sclk(SCLK),
    .mosi(MOSI),
    .busy(shf_busy),
    .done(shf_done),
    .rx_word(shf_rx)
  );

  assign XFER_ACTIVE = shf_busy;

  // Address decode and read data for the access cycle that follows.
  always @* begin
    mapped = (PADDR[1:0] == 2'h0);
    case (idx)
      `SPM_IDX_CON1: rd_byte = con1_reg;
      `SPM_IDX_CON2: rd_byte = con2_reg | `SPM_CON2_ONES;
      `SPM_IDX_DAT1: rd_byte = dat1_reg;
      `SPM_IDX_DAT2: rd_byte = dat2_reg;
      `SPM_IDX_DAT3: rd_byte = dat3_reg;
      `SPM_IDX_ROUTE: rd_byte = `SPM_ROUTE_ONES;
      `SPM_IDX_STAT: rd_byte = {6'h00, stat_reg};
      `SPM_IDX_MASK: rd_byte = {6'h00, mask_reg};
      default: begin
        rd_byte = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  // Register write and hardware update logic.
  always @* begin
    con1_next = con1_reg;
    con2_next = con2_reg;
    dat1_next = dat1_reg;
    dat2_next = dat2_reg;
    dat3_next = dat3_reg;
    route_next = route_reg;
    mask_next = mask_reg;
    start_next = 1'b0;
    if (wr_en) begin
      case (idx)
        `SPM_IDX_CON1: con1_next = wbyte;
        `SPM_IDX_CON2: begin
          con2_next[`SPM_CON2_IEN] = wbyte[`SPM_CON2_IEN];
          con2_next[`SPM_CON2_LEN_HI] = wbyte[`SPM_CON2_LEN_HI];
          con2_next[`SPM_CON2_LEN_LO] = wbyte[`SPM_CON2_LEN_LO];
          con2_next[`SPM_CON2_CI] = wbyte[`SPM_CON2_CI];
          // Writing 1 to the flag leaves it as it is.
          if (!wbyte[`SPM_CON2_DONE]) begin
            con2_next[`SPM_CON2_DONE] = 1'b0;
          end
        end
        `SPM_IDX_DAT1: begin
          if (!shf_busy) begin
            dat1_next = wbyte;
          end
        end
        `SPM_IDX_DAT2: begin
          if (!shf_busy) begin
            dat2_next = wbyte;
          end
        end
        `SPM_IDX_DAT3: begin
          // A write during a running frame is dropped so the word stays intact.
          if (!shf_busy) begin
            dat3_next = wbyte;
            start_next = 1'b1;
            con2_next[`SPM_CON2_DONE] = 1'b0;
          end
        end
        `SPM_IDX_ROUTE: route_next = wbyte[3:0];
        `SPM_IDX_MASK: mask_next = wbyte[1:0];
        default: start_next = 1'b0;
      endcase
    end
    // Received bits replace only the bytes that took part in the frame.
    if (shf_done) begin
      con2_next[`SPM_CON2_DONE] = 1'b1;
      dat1_next = shf_rx[7:0];
      case (con2_reg[`SPM_CON2_LEN_HI:`SPM_CON2_LEN_LO])
        `SPM_LEN_8: begin
          dat1_next = shf_rx[7:0];
        end
        `SPM_LEN_16: begin
          dat2_next = shf_rx[15:8];
          dat1_next = shf_rx[7:0];
        end
        default: begin
          dat3_next = shf_rx[23:16];
          dat2_next = shf_rx[15:8];
          dat1_next = shf_rx[7:0];
        end
      endcase
    end
  end

  // Sticky status: a read clears only the bits it returned, so an event
  // landing between setup and access is not lost.
  always @* begin
    stat_next = stat_reg;
    if (rd_en && idx == `SPM_IDX_STAT) begin
      stat_next = stat_reg & ~PRDATA[1:0];
    end
    if (shf_done) begin
      stat_next[`SPM_ST_XFER] = 1'b1;
    end
    if (peri_req) begin
      stat_next[`SPM_ST_PERI] = 1'b1;
    end
  end

  // Only the documented one-hot routes reach a line; others drive none.
  always @* begin
    case (route_reg)
      4'h1: lines_next = {3'h0, IRQ};
      4'h2: lines_next = {2'h0, IRQ, 1'b0};
      4'h4: lines_next = {1'b0, IRQ, 2'h0};
      4'h8: lines_next = {IRQ, 3'h0};
      default: lines_next = 4'h0;
    endcase
  end

  always @(posedge CLOCK) begin
    if (!NRST) begin
      con1_reg <= `SPM_CON1_RST;
      con2_reg <= `SPM_CON2_RST;
      dat1_reg <= `SPM_DATA_RST;
      dat2_reg <= `SPM_DATA_RST;
      dat3_reg <= `SPM_DATA_RST;
      route_reg <= `SPM_ROUTE_RST;
      stat_reg <= 2'h0;
      mask_reg <= 2'h0;
      start_reg <= 1'b0;
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      CHIP_SEL <= 3'h0;
      IRQ <= 1'b0;
      IRQ_LINES <= 4'h0;
    end else begin
      con1_reg <= con1_next;
      con2_reg <= con2_next;
      dat1_reg <= dat1_next;
      dat2_reg <= dat2_next;
      dat3_reg <= dat3_next;
      route_reg <= route_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      start_reg <= start_next;
      // One wait-free access: ready rises in the cycle after setup.
      if (setup) begin
        PREADY <= 1'b1;
        PSLVERR <= !mapped;
        PRDATA <= (mapped && !PWRITE) ? {24'h000000, rd_byte} : 32'h00000000;
      end else begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
      end
      // Chip select follows the programmed code only while a frame runs.
      if (start_reg || shf_busy) begin
        CHIP_SEL <= con1_reg[`SPM_CON1_CS_HI:0];
      end else begin
        CHIP_SEL <= 3'h0;
      end
      IRQ <= |(stat_next & mask_reg);
      IRQ_LINES <= lines_next;
    end
  end
endmodule

`default_nettype wire

// file: spm_consts.vh
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

// Clock and serial rates, in kHz.
`define SPM_CLK_KHZ 100000
`define SPM_RATE_1M_KHZ 1000
`define SPM_RATE_2M_KHZ 2000
`define SPM_RATE_8M_KHZ 8000
// Half periods of the serial clock in system cycles, rounded up.
`define SPM_HALF_1M ((`SPM_CLK_KHZ + 2*`SPM_RATE_1M_KHZ - 1) / (2*`SPM_RATE_1M_KHZ))
`define SPM_HALF_2M ((`SPM_CLK_KHZ + 2*`SPM_RATE_2M_KHZ - 1) / (2*`SPM_RATE_2M_KHZ))
`define SPM_HALF_8M ((`SPM_CLK_KHZ + 2*`SPM_RATE_8M_KHZ - 1) / (2*`SPM_RATE_8M_KHZ))

// Register indices; the byte address is four times the index.
`define SPM_IDX_CON1 10'h1D8
`define SPM_IDX_CON2 10'h1D9
`define SPM_IDX_DAT1 10'h1DA
`define SPM_IDX_DAT2 10'h1DB
`define SPM_IDX_DAT3 10'h1DC
`define SPM_IDX_ROUTE 10'h1DD
`define SPM_IDX_STAT 10'h1DE
`define SPM_IDX_MASK 10'h1DF

// First control register fields.
`define SPM_CON1_CP 5
`define SPM_CON1_RATE_HI 4
`define SPM_CON1_RATE_LO 3
`define SPM_CON1_CS_HI 2
// Second control register fields (bit n here is data bit n+8).
`define SPM_CON2_IEN 7
`define SPM_CON2_LEN_HI 5
`define SPM_CON2_LEN_LO 4
`define SPM_CON2_DONE 2
`define SPM_CON2_CI 1
`define SPM_CON2_ONES 8'h49
`define SPM_ROUTE_ONES 8'hF0

// Frame length codes.
`define SPM_LEN_8 2'h0
`define SPM_LEN_16 2'h1
`define SPM_LEN_24 2'h3

// Status and mask bits.
`define SPM_ST_XFER 0
`define SPM_ST_PERI 1

// Reset values.
`define SPM_CON1_RST 8'h00
`define SPM_CON2_RST 8'h02
`define SPM_DATA_RST 8'h00
`define SPM_ROUTE_RST 4'h0

`endif

// file: spm_sync.v
`timescale 1ns/1ps
`default_nettype none

module spm_sync #(
  parameter W = 2
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      // The output only moves once the second and third stages agree.
      always @(posedge clk) begin
        if (!rst_n) begin
          s1_reg <= 1'b1;
          s2_reg <= 1'b1;
          s3_reg <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            sync_out[i] <= s3_reg;
          end
        end
      end
    end
  endgenerate
endmodule

`default_nettype wire

// file: spm_shifter.v
`timescale 1ns/1ps
`default_nettype none
`include "spm_consts.vh"

module spm_shifter (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [23:0] word,
  input wire [1:0] len_code,
  input wire cpol,
  input wire cpha,
  input wire [7:0] half_cnt,
  input wire miso,
  output reg sclk,
  output reg mosi,
  output reg busy,
  output reg done,
  output reg [23:0] rx_word
);
  reg [7:0] div_reg;
  reg [5:0] edge_reg;
  reg [5:0] last_reg;
  reg [23:0] tx_reg;
  reg cpol_reg;
  reg cpha_reg;
  reg [23:0] aligned;
  reg [5:0] edges;

  always @* begin
    case (len_code)
      `SPM_LEN_8: begin
        aligned = {word[7:0], 16'h0000};
        edges = 6'h10;
      end
      `SPM_LEN_16: begin
        aligned = {word[15:0], 8'h00};
        edges = 6'h20;
      end
      default: begin
        aligned = word;
        edges = 6'h30;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      div_reg <= 8'h00;
      edge_reg <= 6'h00;
      last_reg <= 6'h00;
      tx_reg <= 24'h000000;
      cpol_reg <= 1'b0;
      cpha_reg <= 1'b0;
      sclk <= 1'b0;
      mosi <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rx_word <= 24'h000000;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        div_reg <= half_cnt - 8'h01;
        edge_reg <= 6'h00;
        last_reg <= edges;
        cpol_reg <= cpol;
        cpha_reg <= cpha;
        sclk <= cpol;
        mosi <= aligned[23];
        // Phase 0 presents the first bit now, phase 1 on the leading edge.
        tx_reg <= cpha ? aligned : {aligned[22:0], 1'b0};
        rx_word <= 24'h000000;
      end else if (busy) begin
        if (div_reg != 8'h00) begin
          div_reg <= div_reg - 8'h01;
        end else begin
          div_reg <= half_cnt - 8'h01;
          if (edge_reg == last_reg) begin
            busy <= 1'b0;
            done <= 1'b1;
            sclk <= cpol_reg;
          end else begin
            sclk <= ~sclk;
            edge_reg <= edge_reg + 6'h01;
            if (edge_reg[0] == cpha_reg) begin
              rx_word <= {rx_word[22:0], miso};
            end else begin
              mosi <= tx_reg[23];
              tx_reg <= {tx_reg[22:0], 1'b0};
            end
          end
        end
      end else begin
        // The idle level follows the idle bit, so a frame never opens with a stray edge.
        sclk <= cpol;
      end
    end
  end
endmodule

`default_nettype wire

// file: spm_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module spm_top_checker (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic SCLK,
  input wire logic [2:0] CHIP_SEL,
  input wire logic XFER_ACTIVE,
  input wire logic IRQ,
  input wire logic [3:0] IRQ_LINES
);
  logic ci_q, sclk_d;
  logic [2:0] cs_q;
  logic [1:0] len_q;
  logic [3:0] rt_q, ci_age;
  logic [5:0] tog;
  wire acc = PSEL && PENABLE && PREADY;
  wire wr = acc && PWRITE;
  // The idle level gets a short grace period after each write to the second control register.
  always @(posedge CLOCK) begin
    if (!NRST) begin
      ci_q <= 1'h1;
      cs_q <= 3'h0;
      len_q <= 2'h0;
      rt_q <= 4'h0;
      ci_age <= 4'h0;
      tog <= 6'h00;
    end else begin
      if (wr && PADDR == 12'h760) cs_q <= PWDATA[2:0];
      if (wr && PADDR == 12'h764) begin
        ci_q <= PWDATA[1];
        len_q <= PWDATA[5:4];
        ci_age <= 4'h0;
      end else if (ci_age != 4'hF) ci_age <= ci_age + 4'h1;
      if (wr && PADDR == 12'h774) rt_q <= PWDATA[3:0];
      tog <= !XFER_ACTIVE ? 6'h00 : tog + {5'h00, SCLK ^ sclk_d};
    end
    sclk_d <= SCLK;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
  property p_ones; acc && !PWRITE && PADDR == 12'h764 |-> (PRDATA[7:0] & 8'h49) == 8'h49;
  endproperty
  property p_route_rd; acc && !PWRITE && PADDR == 12'h774 |-> PRDATA[7:0] == 8'hF0; endproperty
  property p_idle; !XFER_ACTIVE && ci_age > 4'h4 |-> SCLK == !ci_q; endproperty
  property p_start; wr && PADDR == 12'h770 && !XFER_ACTIVE |-> ##[2:4] XFER_ACTIVE; endproperty
  property p_cs; XFER_ACTIVE |-> CHIP_SEL == cs_q; endproperty
  property p_len;
    $fell(XFER_ACTIVE) |-> tog == (len_q == 2'h0 ? 6'h10 : len_q == 2'h1 ? 6'h20 : 6'h30);
  endproperty
  property p_lines;
    1'h1 |-> IRQ_LINES == (($past(IRQ) && $onehot($past(rt_q))) ? $past(rt_q) : 4'h0);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_ones: assert property (p_ones) else $error("unused control bits not one");
  a_route_rd: assert property (p_route_rd) else $error("routing read wrong");
  a_idle: assert property (p_idle) else $error("serial clock idle level wrong");
  a_start: assert property (p_start) else $error("frame did not start");
  a_cs: assert property (p_cs) else $error("chip select differs");
  a_len: assert property (p_len) else $error("clock edge count wrong");
  a_lines: assert property (p_lines) else $error("interrupt line wrong");
  c_start: cover property ($rose(XFER_ACTIVE));
  c_high: cover property (IRQ_LINES == 4'h8);
  c_irq: cover property ($fell(IRQ));
endmodule
bind spm_top spm_top_checker u_chk (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .SCLK(SCLK), .CHIP_SEL(CHIP_SEL), .XFER_ACTIVE(XFER_ACTIVE), .IRQ(IRQ),
  .IRQ_LINES(IRQ_LINES));
`default_nettype wire

// file: spm_periph.sv
`timescale 1ns/1ps
`default_nettype none
module spm_periph (
  input wire logic clock,
  input wire logic [2:0] cs,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ci,
  input wire logic cp,
  input wire logic req,
  output logic miso,
  output logic irq_n,
  output logic [23:0] got
);
  // Data is taken on the edge that the idle and phase bits name as active, but on the leading edge for idle 0 with phase 1.
  always @(posedge sclk or negedge sclk) begin
    if (cs != 3'h0 && sclk == (ci && !cp)) got <= {got[22:0], mosi};
  end
  logic noise = 1'h0;
  always @(posedge clock) noise <= ~noise;
  // A deselected line floats, so a toggling value keeps a stale bit from passing.
  assign miso = (cs != 3'h0) ? ~mosi : noise;
  assign irq_n = ~req;
endmodule
`default_nettype wire

// file: spi_master_frame_data_irq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_frame_data_irq_tb_top;
  logic clock = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic req = 1'h0;
  logic mci = 1'h1;
  logic mcp = 1'h0;
  logic er;
  logic [7:0] rd;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, miso, irq_n, sclk, mosi, xfer, irq;
  wire [2:0] cs;
  wire [3:0] lines;
  wire [23:0] got;
  int fail_count = 0;
  int compares = 0;
  initial forever #5 clock = ~clock;
  spm_top i_dut (.CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MISO(miso), .PERIPH_IRQ_N(irq_n), .SCLK(sclk), .MOSI(mosi), .CHIP_SEL(cs),
    .XFER_ACTIVE(xfer), .IRQ(irq), .IRQ_LINES(lines));
  spm_periph i_periph (.clock(clock), .cs(cs), .sclk(sclk), .mosi(mosi), .ci(mci), .cp(mcp),
    .req(req), .miso(miso), .irq_n(irq_n), .got(got));
  task close_out;
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task regs;
    apb(0, 12'h764, 0); chk(rd, 8'h4B);
    apb(1, 12'h774, 8'h0F); apb(0, 12'h774, 0); chk(rd, 8'hF0);
    apb(0, 12'h780, 0); chk(er, 1'h1);
    apb(0, 12'h765, 0);
    chk(er, 1'h1);
    apb(1, 12'h768, 8'hA5); apb(1, 12'h76C, 8'h3C);
    apb(0, 12'h768, 0); chk(rd, 8'hA5);
    apb(0, 12'h76C, 0); chk(rd, 8'h3C);
  endtask
  task frame(input logic [1:0] lc, rt, input logic ci, cp, input logic [23:0] tx);
    int bits, half, t0, d;
    logic [23:0] ex;
    bits = (lc == 2'h0) ? 8 : (lc == 2'h1) ? 16 : 24;
    half = (rt == 2'h2) ? 25 : (rt == 2'h3) ? 7 : 50;
    // The peripheral echoes inverted bits, so only bytes inside the frame flip.
    ex = tx ^ ((24'h1 << bits) - 24'h1);
    mci = ci;
    mcp = cp;
    apb(1, 12'h760, {2'h0, cp, rt, 3'h5});
    apb(1, 12'h764, {2'h0, lc, 1'h0, 1'h1, ci, 1'h0});
    apb(1, 12'h768, tx[7:0]); apb(1, 12'h76C, tx[15:8]);
    apb(1, 12'h770, tx[23:16]);
    t0 = $time;
    apb(0, 12'h764, 0); chk(rd[2], 1'h0);
    // Both writes land while the frame runs and must be dropped.
    apb(1, 12'h76C, ~tx[15:8]);
    apb(1, 12'h770, ~tx[23:16]);
    repeat (3000) if (xfer) @(posedge clock);
    chk((got ^ tx) & (ex ^ tx), 32'h0);
    d = ($time - t0) / 10 - (2 * bits + 1) * half;
    chk(d >= 0 && d <= 6, 1'h1);
    apb(0, 12'h764, 0); chk(rd[2], 1'h1);
    apb(0, 12'h768, 0); chk(rd, ex[7:0]);
    apb(0, 12'h76C, 0); chk(rd, ex[15:8]);
    apb(0, 12'h770, 0); chk(rd, ex[23:16]);
  endtask
  task irqs;
    apb(1, 12'h77C, 8'h01); apb(1, 12'h774, 8'h02);
    frame(2'h0, 2'h3, 1'h1, 1'h0, 24'h123456);
    repeat (3) @(posedge clock);
    chk(irq, 1'h1); chk(lines, 4'h2);
    apb(0, 12'h778, 0); chk(rd, 8'h01);
    repeat (3) @(posedge clock);
    chk(irq, 1'h0);
    apb(1, 12'h764, 8'h00); apb(0, 12'h764, 0); chk(rd[2], 1'h0);
    req <= 1'h1;
    repeat (10) @(posedge clock);
    apb(0, 12'h778, 0); chk(rd, 8'h00);
    apb(1, 12'h764, 8'h82);
    repeat (10) @(posedge clock);
    apb(0, 12'h778, 0); chk(rd, 8'h02);
    apb(1, 12'h77C, 8'h02);
    for (int i = 0; i < 5; i++) begin
      apb(1, 12'h774, (i == 0) ? 8'h00 : 8'h01 << (i - 1));
      repeat (4) @(posedge clock);
      chk(lines, (i == 0) ? 4'h0 : 4'h1 << (i - 1));
    end
    req <= 1'h0;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'h1;
    regs;
    frame(2'h0, 2'h0, 1'h1, 1'h0, 24'hC35A96);
    frame(2'h1, 2'h2, 1'h1, 1'h1, 24'h0F5AA3);
    frame(2'h3, 2'h3, 1'h0, 1'h0, 24'h96C3E1);
    frame(2'h0, 2'h1, 1'h1, 1'h1, 24'h3CA55A);
    irqs;
    close_out;
  end
  initial begin
    // The run needs about three thousand cycles; this allows over six times that.
    #200000;
    fail_count++;
    close_out;
  end
endmodule
`default_nettype wire
